// >>> pors_pkg.sv
package pors_pkg;
  // AXI4-Lite register map (byte addresses)
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] STAT_OFFS = 8'h04;
  localparam logic [7:0] STRAP_OFFS = 8'h08;
  localparam logic [7:0] WDOG_OFFS = 8'h0c;
  // Control register fields
  localparam int CTRL_WDOG_EN_BIT = 0;
  localparam int CTRL_WDOG_KICK_BIT = 1;
  // Status register fields
  localparam int STAT_POR_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_HARD_BIT = 2;
  localparam int STAT_SOFT_BIT = 3;
  localparam int STAT_WDOG_BIT = 4;
  // Timing counts in board clock cycles; the lock wait is in PLL reference cycles
  localparam int POR_HOLD_CYC = 16;
  localparam int POR_STRETCH_CYC = 1024;
  localparam int PLL_LOCK_REF_CYC = 6400;
  localparam int HARD_REL_CYC = 512;
  localparam int SOFT_REL_CYC = 515;
  localparam int STRAP_W = 14;
  localparam logic [31:0] WDOG_RESET_VAL = 32'h0000ffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_EXT, ST_STRETCH, ST_LOCK, ST_HARD, ST_SOFT, ST_RUN} pors_state_t;
endpackage

// >>> pors_sequencer.sv
// Behaviour
// - Internal power-on reset stays asserted 1024 clocks after the external input is released.
// - The PLL reports lock 6400 reference cycles after internal reset release, reference = clock / divider.
// - After lock, hard_reset_n is driven low 512 more clocks and then released.
// - After lock, soft_reset_n is driven low 515 more clocks, three after hard reset release.
// - Hard and soft reset counts run on the input clock itself.
// - Fourteen configuration straps are latched as power-on reset deasserts.
// - Soft reset is asserted whenever hard reset is asserted.
// - An enabled watchdog reaching zero launches an internal hard reset sequence.
`timescale 1ns/1ps
`default_nettype none
module pors_sequencer
  import pors_pkg::*;
#(
  parameter int STRETCH_CYC = POR_STRETCH_CYC,
  parameter int LOCK_REF_CYC = PLL_LOCK_REF_CYC,
  parameter logic [2:0] PLL_REF_DIV = 3'h1
) (
  // Clock and bus reset
  input wire logic aclk,
  input wire logic aresetn,
  // Board reset and straps
  input wire logic power_on_reset_n,
  input wire logic [STRAP_W-1:0] cfg_straps,
  // Open-drain resets, low drive when enable high
  output logic hard_reset_o,
  output logic hard_reset_oe,
  input wire logic hard_reset_i,
  output logic soft_reset_o,
  output logic soft_reset_oe,
  input wire logic soft_reset_i,
  output logic internal_por_n,
  output logic system_pll_locked,
  output logic [STRAP_W-1:0] cfg_latched,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  pors_state_t state_q;
  logic [19:0] cnt_q;
  logic por_q;
  logic wdog_en_q;
  logic wdog_fire_q;
  logic [31:0] wdog_load_q;
  logic [31:0] wdog_cnt_q;
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go, wr_hit_ctrl, wr_hit_wdog;
  logic [19:0] lock_cyc;

  // Lock wait measured in board clocks: reference runs at clock / divider
  assign lock_cyc = 20'(LOCK_REF_CYC * int'(PLL_REF_DIV));

  // Reset sequence; power_on_reset_n low restarts the state machine and its count, ignoring bus reset
  always_ff @(posedge aclk) begin
    por_q <= power_on_reset_n;
    if (!power_on_reset_n) begin
      state_q <= ST_EXT;
      cnt_q <= 20'h00000;
    end else begin
      case (state_q)
        ST_EXT: begin
          state_q <= ST_STRETCH;
          cnt_q <= 20'h00001;
        end
        ST_STRETCH: begin
          if (cnt_q == 20'(STRETCH_CYC)) begin
            state_q <= ST_LOCK;
            cnt_q <= 20'h00001;
          end else cnt_q <= cnt_q + 20'h00001;
        end
        ST_LOCK: begin
          if (cnt_q == lock_cyc) begin
            state_q <= ST_HARD;
            cnt_q <= 20'h00001;
          end else cnt_q <= cnt_q + 20'h00001;
        end
        ST_HARD, ST_SOFT: begin
          // Counts run on aclk itself, which is the bus reference clock
          if (wdog_fire_q) begin
            state_q <= ST_HARD;
            cnt_q <= 20'h00001;
          end else if (state_q == ST_HARD && cnt_q == 20'(HARD_REL_CYC)) begin
            state_q <= ST_SOFT;
            cnt_q <= cnt_q + 20'h00001;
          end else if (state_q == ST_SOFT && cnt_q == 20'(SOFT_REL_CYC)) begin
            state_q <= ST_RUN;
          end else cnt_q <= cnt_q + 20'h00001;
        end
        ST_RUN: begin
          if (wdog_fire_q) begin
            state_q <= ST_HARD;
            cnt_q <= 20'h00001;
          end
        end
        default: state_q <= ST_EXT;
      endcase
    end
  end

  // Registered outputs; hard reset drive always implies soft reset drive
  always_ff @(posedge aclk) begin
    if (!power_on_reset_n) begin
      internal_por_n <= 1'b0;
      system_pll_locked <= 1'b0;
      hard_reset_oe <= 1'b1;
      soft_reset_oe <= 1'b1;
    end else begin
      internal_por_n <= !(state_q == ST_EXT || state_q == ST_STRETCH);
      system_pll_locked <= state_q inside {ST_HARD, ST_SOFT, ST_RUN};
      hard_reset_oe <= state_q != ST_SOFT && state_q != ST_RUN;
      soft_reset_oe <= state_q != ST_RUN;
    end
  end
  assign hard_reset_o = 1'b0;
  assign soft_reset_o = 1'b0;

  // Straps captured on the rising edge of power_on_reset_n, a clocked sample
  always_ff @(posedge aclk) begin
    if (power_on_reset_n && !por_q) cfg_latched <= cfg_straps;
  end

  // Watchdog counts down only while enabled and the device is running
  always_ff @(posedge aclk) begin
    if (!aresetn || !power_on_reset_n) begin
      wdog_cnt_q <= WDOG_RESET_VAL;
      wdog_fire_q <= 1'b0;
    end else begin
      wdog_fire_q <= 1'b0;
      if (wr_hit_ctrl && wdata_q[CTRL_WDOG_KICK_BIT]) wdog_cnt_q <= wdog_load_q;
      else if (wdog_en_q && state_q == ST_RUN) begin
        if (wdog_cnt_q == 32'h00000000) begin
          wdog_fire_q <= 1'b1;
          wdog_cnt_q <= wdog_load_q;
        end else wdog_cnt_q <= wdog_cnt_q - 32'h00000001;
      end
    end
  end

  // Write channel: address and data taken in either order
  assign wr_go = aw_q && w_q && !s_bvalid;
  assign wr_hit_ctrl = wr_go && awaddr_q == CTRL_OFFS && wstrb_q[0];
  assign wr_hit_wdog = wr_go && awaddr_q == WDOG_OFFS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      wdog_en_q <= 1'b0;
      wdog_load_q <= WDOG_RESET_VAL;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= (awaddr_q == CTRL_OFFS || awaddr_q == WDOG_OFFS) ? RESP_OKAY : RESP_SLVERR;
        if (wr_hit_ctrl) wdog_en_q <= wdata_q[CTRL_WDOG_EN_BIT];
        if (wr_hit_wdog) begin
          for (int b = 0; b < 4; b++) begin
            if (wstrb_q[b]) wdog_load_q[8*b +: 8] <= wdata_q[8*b +: 8];
          end
        end
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // Read channel: one read at a time, answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= RESP_OKAY;
      case (s_araddr)
        CTRL_OFFS: s_rdata <= {31'h00000000, wdog_en_q};
        STAT_OFFS: s_rdata <= {27'h0000000, wdog_cnt_q == 32'h00000000, !soft_reset_i, !hard_reset_i,
                               system_pll_locked, internal_por_n};
        STRAP_OFFS: s_rdata <= {18'h00000, cfg_latched};
        WDOG_OFFS: s_rdata <= wdog_load_q;
        default: begin
          s_rdata <= 32'h00000000;
          s_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // Checks
  hard_rel_time_a: assert property (@(posedge aclk) disable iff (!power_on_reset_n)
    $rose(system_pll_locked) |-> hard_reset_oe [*8]);
  soft_with_hard_a: assert property (@(posedge aclk) disable iff (!power_on_reset_n)
    hard_reset_oe |-> soft_reset_oe);
  soft_after_hard_a: assert property (@(posedge aclk) disable iff (!power_on_reset_n)
    $fell(hard_reset_oe) |-> soft_reset_oe ##1 soft_reset_oe ##1 soft_reset_oe ##1 !soft_reset_oe);
  por_stretch_a: assert property (@(posedge aclk) disable iff (!power_on_reset_n)
    $rose(power_on_reset_n) |-> !internal_por_n [*8]);
  lock_after_por_a: assert property (@(posedge aclk) disable iff (!power_on_reset_n)
    $rose(internal_por_n) |-> !system_pll_locked [*8]);
  wdog_relaunch_a: assert property (@(posedge aclk) disable iff (!power_on_reset_n)
    wdog_fire_q |-> ##2 hard_reset_oe);
  strap_latch_a: assert property (@(posedge aclk)
    power_on_reset_n && !por_q |=> cfg_latched == $past(cfg_straps));
  bus_reference_clock_count_a: assert property (@(posedge aclk) disable iff (!power_on_reset_n)
    state_q == ST_HARD && !wdog_fire_q && cnt_q < 20'(HARD_REL_CYC) |=> cnt_q == $past(cnt_q) + 20'h00001);
endmodule
`default_nettype wire

// >>> pors_board.sv
`timescale 1ns/1ps
`default_nettype none
module pors_board (
  // Clock
  input wire logic aclk,
  // Strap levels to present
  input wire logic [13:0] strap_val,
  // Device pins
  input wire logic hard_oe,
  input wire logic soft_oe,
  output logic por_n,
  output logic [13:0] straps,
  output logic hard_pin,
  output logic soft_pin
);
  int cnt = 40;
  // Supervisor holds reset from power-up, then lets the straps go stale
  always_ff @(posedge aclk) begin
    if (cnt > 0) cnt <= cnt - 1;
  end
  assign por_n = !(cnt > 4);
  // Hold time over: show the inverse so a late capture is caught
  assign straps = (cnt > 0) ? strap_val : ~strap_val;
  // Open drain with board pull-up
  assign hard_pin = !hard_oe;
  assign soft_pin = !soft_oe;
endmodule
`default_nettype wire

// >>> power_on_reset_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module power_on_reset_sequencer_tb_top;
  import pors_pkg::*;
  localparam int STR = 8;
  localparam int LCK = 10;
  logic aclk = 0, aresetn = 0, hoe, soe, ho, so, hpin, spin, ipor_n, lock, por_n;
  logic [13:0] sv = 0, straps, latched;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [33:0] q[$], e;
  int err_count = 0, num_checks = 0, cyc = 0, t0;
  pors_sequencer #(.STRETCH_CYC(STR), .LOCK_REF_CYC(LCK), .PLL_REF_DIV(3'h2)) pors_sequencer_i (
    .aclk(aclk), .aresetn(aresetn), .power_on_reset_n(por_n), .cfg_straps(straps),
    .hard_reset_o(ho), .hard_reset_oe(hoe), .hard_reset_i(hpin), .soft_reset_o(so),
    .soft_reset_oe(soe), .soft_reset_i(spin), .internal_por_n(ipor_n), .system_pll_locked(lock),
    .cfg_latched(latched), .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
  pors_board pors_board_i (.aclk(aclk), .strap_val(sv), .hard_oe(hoe), .soft_oe(soe),
    .por_n(por_n), .straps(straps), .hard_pin(hpin), .soft_pin(spin));
  // Clock and cycle count; the ceiling cuts a hang short
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc > 6000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      err_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Write: address and data offered together, each dropped when taken; the response is noted first
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    q.push_back({r, 32'h00000000});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
    end while (bvalid !== 1'b1);
    bready <= 0;
  endtask
  // Read: the expected answer is noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    q.push_back(x);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 0;
    end while (rvalid !== 1'b1);
    rready <= 0;
  endtask
  // Response monitor takes the oldest note on each read or write response
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = q.pop_front();
      chk({rresp, rdata} === e, "read data");
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      e = q.pop_front();
      chk({bresp, 32'h00000000} === e, "write response");
    end
  end
  // Soft reset must cover every cycle of hard reset
  always @(posedge aclk) begin
    if (hoe === 1'b1) chk(soe === 1'b1, "soft reset released under hard");
  end
  // Release order after a hard reset start; full also checks the hard release count from t0
  task automatic seq(input logic full);
    chk(ho === 1'b0 && so === 1'b0, "open-drain data not low");
    do @(posedge aclk); while (hoe !== 1'b0);
    if (full) chk(cyc - t0 == HARD_REL_CYC, "hard release count");
    t0 = cyc;
    do @(posedge aclk); while (soe !== 1'b0);
    chk(cyc - t0 == SOFT_REL_CYC - HARD_REL_CYC, "soft release gap");
  endtask
  initial begin
    void'($urandom(43406));
    sv = 14'($urandom);
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    do @(posedge aclk); while (por_n !== 1'b1);
    t0 = cyc;
    do @(posedge aclk); while (ipor_n !== 1'b1);
    chk(cyc - t0 >= STR && cyc - t0 <= STR + 3, "stretch");
    t0 = cyc;
    do @(posedge aclk); while (lock !== 1'b1);
    chk(cyc - t0 >= LCK * 2 && cyc - t0 <= LCK * 2 + 2, "lock wait");
    t0 = cyc;
    seq(1);
    chk(latched === sv, "strap capture");
    rd(STRAP_OFFS, {RESP_OKAY, 18'h0, sv});
    rd(STAT_OFFS, {RESP_OKAY, 32'h3});
    rd(8'h10, {RESP_SLVERR, 32'h0});
    wr(8'h10, 32'h0000005a, 4'hf, RESP_SLVERR);
    $display("test power-on sequence done");
    wr(WDOG_OFFS, 32'h28, 4'hf, RESP_OKAY);
    wr(CTRL_OFFS, 32'h3, 4'hf, RESP_OKAY);
    t0 = cyc;
    do @(posedge aclk); while (hoe !== 1'b1);
    chk(cyc - t0 >= 40 && cyc - t0 <= 60, "watchdog expiry");
    // Relaunched sequence counts from the cycle hard reset shows again
    t0 = cyc;
    wr(CTRL_OFFS, 32'h0, 4'hf, RESP_OKAY);
    rd(STAT_OFFS, {RESP_OKAY, 32'hf});
    seq(1);
    // Byte strobes: only the low byte of the load value may change
    wr(WDOG_OFFS, {18'h0, sv}, 4'h1, RESP_OKAY);
    rd(WDOG_OFFS, {RESP_OKAY, 24'h0, sv[7:0]});
    $display("test watchdog done");
    end_sim();
  end
endmodule
`default_nettype wire
